// ===== hw/sct_consts.vh
// constants for the synchronous character transmitter
`ifndef SCT_CONSTS_VH
`define SCT_CONSTS_VH
`define SCT_DATA_W        8
`define SCT_FILL_RST      8'hff
`define SCT_WLS_5         2'h0
`define SCT_WLS_6         2'h1
`define SCT_WLS_7         2'h2
`define SCT_WLS_8         2'h3
`define SCT_CTRL_WLS_LSB  2
`define SCT_CTRL_PI_BIT   1
`define SCT_CTRL_EPE_BIT  0
`define SCT_CTRL_RST      8'h0c
`define SCT_IRQ_NODATA    0
`define SCT_IRQ_EMPTY     1
`define SCT_IRQ_W         2
`define SCT_REG_STAT      4'h0
`define SCT_REG_MASK      4'h1
`define SCT_REG_CTRL      4'h2
`define SCT_REG_FLAGS     4'h3
`endif

// ===== hw/sct_transmitter.v
// synchronous character transmitter: holding, fill, shift logic and register port
`timescale 1ns/1ps
`include "sct_consts.vh"
module sct_transmitter #(
  parameter DATA_W = `SCT_DATA_W
) (
  // clock and reset
  input  wire              i_ref_clk,
  input  wire              i_arst_n,
  // link pins from outside the clock domain
  input  wire              i_tx_clk,
  input  wire              i_clear_to_send,
  input  wire              i_master_clear,
  // host loading pins
  input  wire [DATA_W-1:0] i_tx_hold_data_in,
  input  wire              i_hold_load_n,
  input  wire [DATA_W-1:0] i_fill_char_in,
  input  wire              i_fill_load_n,
  input  wire [7:0]        i_ctrl_in,
  input  wire              i_ctrl_load_n,
  input  wire              i_chip_off,
  // serial side and flags
  output reg               o_serial_tx_out,
  output wire              o_serial_tx_oe,
  output reg               o_last_bit_flag,
  output reg               o_hold_empty_flag,
  output reg               o_no_data_flag,
  // register port
  input  wire [3:0]        i_reg_addr,
  input  wire [7:0]        i_reg_wdata,
  input  wire              i_reg_wr,
  input  wire              i_reg_rd,
  output reg  [7:0]        o_reg_rdata,
  output wire              o_irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  // two-flop synchronisers for every link pin, load strobe and the chip-off pin
  reg [1:0] s_clk_r;
  reg [1:0] s_cts_r;
  reg [1:0] s_mc_r;
  reg [1:0] s_hl_r;
  reg [1:0] s_fl_r;
  reg [1:0] s_cl_r;
  reg [1:0] s_off_r;
  reg       clk_d_r;
  // delayed holding strobe, finds the start of a load
  reg       hl_d_r;

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_clk_r <= 2'h0;
      s_cts_r <= 2'h0;
      s_mc_r  <= 2'h0;
      s_hl_r  <= 2'h3;
      s_fl_r  <= 2'h3;
      s_cl_r  <= 2'h3;
      s_off_r <= 2'h0;
      clk_d_r <= 1'b0;
      hl_d_r  <= 1'b1;
    end else begin
      s_clk_r <= {s_clk_r[0], i_tx_clk};
      s_cts_r <= {s_cts_r[0], i_clear_to_send};
      s_mc_r  <= {s_mc_r[0], i_master_clear};
      s_hl_r  <= {s_hl_r[0], i_hold_load_n};
      s_fl_r  <= {s_fl_r[0], i_fill_load_n};
      s_cl_r  <= {s_cl_r[0], i_ctrl_load_n};
      s_off_r <= {s_off_r[0], i_chip_off};
      clk_d_r <= s_clk_r[1];
      hl_d_r  <= s_hl_r[1];
    end
  end

  wire en      = ~s_off_r[1];
  wire mclr    = s_mc_r[1];
  wire cts     = s_cts_r[1];
  // rising link clock edge starts a bit, falling edge marks its centre
  wire bit_beg = s_clk_r[1] & ~clk_d_r;
  wire bit_mid = ~s_clk_r[1] & clk_d_r;
  wire hold_ld = en & ~s_hl_r[1];
  // the holding register is marked full once per strobe, on its leading edge;
  // a level test would mark a character as new again after it has
  // already moved into the shift register while the strobe is still low
  wire hold_fall = en & ~s_hl_r[1] & hl_d_r;
  wire fill_ld = en & ~s_fl_r[1];
  wire ctrl_ld = en & ~s_cl_r[1];

  // length decode
  // bits the selected length keeps
  function [3:0] len_of;
    input [1:0] wls;
    begin
      len_of = 4'h5 + {2'h0, wls};
    end
  endfunction

  // zero upper bits beyond the selected length
  function [7:0] trim;
    input [7:0] d;
    input [1:0] wls;
    begin
      case (wls)
        `SCT_WLS_5: trim = {3'h0, d[4:0]};
        `SCT_WLS_6: trim = {2'h0, d[5:0]};
        `SCT_WLS_7: trim = {1'h0, d[6:0]};
        default:    trim = d;
      endcase
    end
  endfunction

  reg [7:0]  ctrl_r;
  reg [7:0]  hold_r;
  reg [7:0]  fill_r;
  reg [8:0]  shift_r;
  reg [3:0]  bits_left_r;
  reg        state_r;
  reg        pick_hold_r;
  reg        chosen_r;
  reg [`SCT_IRQ_W-1:0] stat_r;
  reg [`SCT_IRQ_W-1:0] mask_r;
  reg        sw_cts_en_r;

  wire [1:0] wls      = ctrl_r[`SCT_CTRL_WLS_LSB+1:`SCT_CTRL_WLS_LSB];
  wire       par_off  = ctrl_r[`SCT_CTRL_PI_BIT];
  wire       par_even = ctrl_r[`SCT_CTRL_EPE_BIT];
  wire [3:0] clen     = len_of(wls) + {3'h0, ~par_off};
  wire       go       = cts & sw_cts_en_r;

  // frame a character with parity appended above its msb
  function [8:0] frame;
    input [7:0] d;
    input [1:0] w;
    input       poff;
    input       peven;
    reg   [7:0] t;
    reg         p;
    begin
      t = trim(d, w);
      p = ~(^t) ^ peven;
      case (w)
        `SCT_WLS_5: frame = {3'h0, p & ~poff, t[4:0]};
        `SCT_WLS_6: frame = {2'h0, p & ~poff, t[5:0]};
        `SCT_WLS_7: frame = {1'h0, p & ~poff, t[6:0]};
        default:    frame = {p & ~poff, t};
      endcase
    end
  endfunction

  wire last_bit  = (state_r == ST_SEND) && (bits_left_r == 4'h1);
  wire hold_full = ~o_hold_empty_flag;
  wire ev_fill   = bit_beg & last_bit & go & chosen_r & ~pick_hold_r;
  wire ev_empty  = bit_beg & go & ~hold_fall & hold_full &
                   ((state_r == ST_IDLE) | (last_bit & pick_hold_r));

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_r            <= `SCT_CTRL_RST;
      hold_r            <= 8'h00;
      fill_r            <= `SCT_FILL_RST;
      shift_r           <= 9'h1ff;
      bits_left_r       <= 4'h0;
      state_r           <= ST_IDLE;
      pick_hold_r       <= 1'b0;
      chosen_r          <= 1'b0;
      o_serial_tx_out   <= 1'b1;
      o_last_bit_flag   <= 1'b0;
      o_hold_empty_flag <= 1'b1;
      o_no_data_flag    <= 1'b0;
    end else if (mclr) begin
      hold_r            <= 8'h00;
      fill_r            <= `SCT_FILL_RST;
      shift_r           <= 9'h1ff;
      bits_left_r       <= 4'h0;
      state_r           <= ST_IDLE;
      pick_hold_r       <= 1'b0;
      chosen_r          <= 1'b0;
      o_serial_tx_out   <= 1'b1;
      o_last_bit_flag   <= 1'b0;
      o_hold_empty_flag <= 1'b1;
      o_no_data_flag    <= 1'b0;
    end else begin
      if (ctrl_ld)
        ctrl_r <= i_ctrl_in;
      if (fill_ld)
        fill_r <= trim(i_fill_char_in, wls);
      // no-data clear
      // the latch stays open while the strobe is low, data must not move
      if (hold_ld) begin
        hold_r         <= trim(i_tx_hold_data_in, wls);
        o_no_data_flag <= 1'b0;
      end
      // only a fresh strobe marks the holding register full
      if (hold_fall)
        o_hold_empty_flag <= 1'b0;
      if (bit_mid && last_bit) begin
        pick_hold_r <= hold_full | hold_ld;
        chosen_r    <= 1'b1;
      end
      if (bit_beg) begin
        chosen_r <= 1'b0;
        if (state_r == ST_SEND && !last_bit) begin
          shift_r         <= {1'b1, shift_r[8:1]};
          o_serial_tx_out <= shift_r[1];
          bits_left_r     <= bits_left_r - 4'h1;
          o_last_bit_flag <= (bits_left_r != 4'h2);
        end else if (go && (state_r == ST_IDLE ? hold_full
                                               : (chosen_r | hold_full))) begin
          state_r     <= ST_SEND;
          bits_left_r <= clen;
          o_last_bit_flag <= (clen != 4'h1);
          if (state_r == ST_IDLE || pick_hold_r) begin
            shift_r           <= frame(hold_r, wls, par_off, par_even);
            o_serial_tx_out   <= hold_r[0];
            // a load that starts in this very cycle wins over the move
            if (!hold_fall)
              o_hold_empty_flag <= 1'b1;
          end else begin
            shift_r         <= frame(fill_r, wls, par_off, par_even);
            o_serial_tx_out <= fill_r[0];
            if (!hold_ld)
              o_no_data_flag <= 1'b1;
          end
        end else begin
          state_r         <= ST_IDLE;
          bits_left_r     <= 4'h0;
          o_serial_tx_out <= 1'b1;
          o_last_bit_flag <= 1'b0;
        end
      end
    end
  end

  // register port; sticky status, set wins over read-clear
  wire stat_rd = i_reg_rd && (i_reg_addr == `SCT_REG_STAT);
  wire [`SCT_IRQ_W-1:0] ev = {ev_empty, ev_fill};

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_r      <= {`SCT_IRQ_W{1'b0}};
      mask_r      <= {`SCT_IRQ_W{1'b0}};
      sw_cts_en_r <= 1'b1;
      o_reg_rdata <= 8'h00;
    end else begin
      stat_r <= (stat_rd ? {`SCT_IRQ_W{1'b0}} : stat_r) | ev;
      if (i_reg_wr && i_reg_addr == `SCT_REG_MASK)
        mask_r <= i_reg_wdata[`SCT_IRQ_W-1:0];
      if (i_reg_wr && i_reg_addr == `SCT_REG_CTRL)
        sw_cts_en_r <= i_reg_wdata[0];
      o_reg_rdata <= 8'h00;
      if (i_reg_rd) begin
        case (i_reg_addr)
          `SCT_REG_STAT:  o_reg_rdata <= {6'h00, stat_r};
          `SCT_REG_MASK:  o_reg_rdata <= {6'h00, mask_r};
          `SCT_REG_CTRL:  o_reg_rdata <= {7'h00, sw_cts_en_r};
          `SCT_REG_FLAGS: o_reg_rdata <= {3'h0, state_r, o_last_bit_flag,
                                          o_no_data_flag, o_hold_empty_flag,
                                          o_serial_tx_out};
          default:        o_reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  assign o_irq          = |(stat_r & mask_r);
  // the serial pin floats only while the chip is switched off
  assign o_serial_tx_oe = en;

endmodule // sct_transmitter

// ===== sim/sct_link_model.sv
// modem side model: times-one clock source and serial bit sampler
`timescale 1ns/1ps
module sct_link_model (
  // serial line in, bit clock out
  input  wire logic i_serial,
  output logic      o_tx_clk
);
  logic rxb [0:4095];
  int   cnt = 0;
  // one clock per bit, phase unrelated to the system clock
  initial begin
    o_tx_clk = 1'b0;
    #23;
    forever #400 o_tx_clk = ~o_tx_clk;
  end
  // sample at the next bit start, before the line moves
  always @(posedge o_tx_clk) begin
    rxb[cnt] <= i_serial;
    cnt <= cnt + 1;
  end
endmodule // sct_link_model

// ===== sim/sct_testbench.sv
// self-checking bench for the synchronous character transmitter
`timescale 1ns/1ps
module testbench;
  logic       i_ref_clk, i_arst_n, i_clear_to_send, i_master_clear, i_hold_load_n;
  logic       i_fill_load_n, i_chip_off, i_reg_wr, i_reg_rd, tx_clk, o_irq;
  logic [7:0] i_tx_hold_data_in, i_fill_char_in, i_ctrl_in, i_reg_wdata, o_reg_rdata;
  logic [3:0] i_reg_addr;
  logic       o_serial_tx_out, o_serial_tx_oe, o_last_bit_flag, o_hold_empty_flag, o_no_data_flag;
  int         err_count = 0, checked = 0, tgt, n0, n1;
  sct_transmitter u_sct_transmitter (.i_tx_clk(tx_clk), .i_ctrl_load_n(1'b0), .*);
  sct_link_model u_sct_link_model (.i_serial(o_serial_tx_out), .o_tx_clk(tx_clk));
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic bit met(input int s);
    case (s)
      0: return o_hold_empty_flag === 1'b1;
      default: return u_sct_link_model.cnt >= tgt;
    endcase
  endfunction
  task automatic wt(input int s);
    int k;
    for (k = 0; k < 2000 && !met(s); k++) @(posedge i_ref_clk);
    if (k == 2000) begin
      err_count++;
      $display("Error at %0t: wait %0d timed out", $time, s);
      close_out();
    end
  endtask
  task automatic rw(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= w;
    i_reg_rd <= !w;
    @(posedge i_ref_clk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
    @(negedge i_ref_clk);
  endtask
  task automatic ld(input logic f, input logic [7:0] d);
    @(posedge i_ref_clk);
    if (f) i_fill_char_in <= d;
    else i_tx_hold_data_in <= d;
    i_fill_load_n <= !f;
    i_hold_load_n <= f;
    repeat (4) @(posedge i_ref_clk);
    i_fill_load_n <= 1'b1;
    i_hold_load_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  task automatic cc(input int n, input logic [7:0] d, input int len, input logic par);
    tgt = n + len + 2;
    wt(1);
    for (int i = 0; i < len; i++) chk(8'(u_sct_link_model.rxb[n + i]), 8'(d[i]));
    if (par) chk(8'(u_sct_link_model.rxb[n + len]), 8'(~^(d & (8'hff >> (8 - len)))));
  endtask
  task automatic t_reset;
    chk(8'({o_serial_tx_out, o_hold_empty_flag, o_last_bit_flag, o_no_data_flag, o_irq}), 8'h18);
    rw(0, 4'h2, 8'h00);
    chk(o_reg_rdata, 8'h01);
    rw(0, 4'h9, 8'h00);
    chk(o_reg_rdata, 8'h00);
    rw(0, 4'h3, 8'h00);
    chk(o_reg_rdata, 8'h03);
    $display("t_reset done");
  endtask
  task automatic t_wlen;
    for (int w = 0; w < 4; w++) begin
      i_ctrl_in <= {4'h0, 2'(w), 2'b10};
      ld(0, 8'he6);
      wt(0);
      n0 = u_sct_link_model.cnt;
      ld(0, 8'h39);
      wt(0);
      n1 = u_sct_link_model.cnt;
      chk(8'(n1 - n0), 8'(5 + w));
      cc(n0, 8'he6, 5 + w, 0);
      cc(n1, 8'h39, 5 + w, 0);
    end
    $display("t_wlen done");
  endtask
  task automatic t_fill;
    rw(1, 4'h1, 8'h00);
    repeat (2) @(negedge i_ref_clk);
    chk(8'(o_irq), 8'h00);
    rw(1, 4'h1, 8'h01);
    repeat (2) @(negedge i_ref_clk);
    chk(8'(o_irq), 8'h01);
    i_ctrl_in <= 8'h0c;
    ld(1, 8'h3c);
    ld(0, 8'h5b);
    chk(8'(o_no_data_flag), 8'h00);
    wt(0);
    n0 = u_sct_link_model.cnt;
    cc(n0, 8'h5b, 8, 1);
    cc(n0 + 9, 8'h3c, 8, 1);
    chk(8'(o_no_data_flag), 8'h01);
    rw(0, 4'h0, 8'h00);
    chk(o_reg_rdata, 8'h03);
    repeat (2) @(negedge i_ref_clk);
    chk(8'(o_irq), 8'h00);
    $display("t_fill done");
  endtask
  task automatic t_cts;
    ld(0, 8'hc3);
    wt(0);
    n0 = u_sct_link_model.cnt;
    i_clear_to_send <= 1'b0;
    ld(0, 8'h96);
    cc(n0, 8'hc3, 8, 1);
    tgt = n0 + 15;
    wt(1);
    for (int i = 10; i < 14; i++) chk(8'(u_sct_link_model.rxb[n0 + i]), 8'h01);
    chk(8'(o_hold_empty_flag), 8'h00);
    i_clear_to_send <= 1'b1;
    wt(0);
    n0 = u_sct_link_model.cnt;
    cc(n0, 8'h96, 8, 1);
    $display("t_cts done");
  endtask
  task automatic t_mc;
    ld(0, 8'ha5);
    wt(0);
    i_master_clear <= 1'b1;
    i_chip_off <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk(8'({o_serial_tx_out, o_hold_empty_flag, o_last_bit_flag, o_no_data_flag, o_serial_tx_oe}), 8'h18);
    i_master_clear <= 1'b0;
    i_chip_off <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    ld(0, 8'h00);
    wt(0);
    n0 = u_sct_link_model.cnt;
    cc(n0 + 9, 8'hff, 8, 1);
    $display("t_mc done");
  endtask
  initial begin
    i_arst_n = 1'b0;
    i_clear_to_send = 1'b1;
    i_master_clear = 1'b0;
    {i_hold_load_n, i_fill_load_n, i_chip_off, i_reg_wr, i_reg_rd} = 5'h18;
    {i_tx_hold_data_in, i_fill_char_in, i_reg_wdata, i_reg_addr} = 28'h0;
    i_ctrl_in = 8'h0c;
    repeat (4) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_wlen();
    t_fill();
    t_cts();
    t_mc();
    close_out();
  end
endmodule // testbench

// ===== sim/sct_transmitter_asserts.sv
// port checker for the synchronous character transmitter
`timescale 1ns/1ps
module sct_transmitter_chk (
  // clock, reset and driving pins
  input logic       i_ref_clk,
  input logic       i_arst_n,
  input logic       i_master_clear,
  input logic       i_chip_off,
  input logic       i_hold_load_n,
  input logic       i_reg_rd,
  // observed outputs
  input logic       o_serial_tx_out,
  input logic       o_serial_tx_oe,
  input logic       o_last_bit_flag,
  input logic       o_hold_empty_flag,
  input logic       o_no_data_flag,
  input logic       o_irq,
  input logic [7:0] o_reg_rdata
);
  default clocking cb @(posedge i_ref_clk); endclocking
  // master clear may cut a character short, so flag timing is not judged under it
  default disable iff (!i_arst_n || i_master_clear);
  AST_RD_QUIET: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
    else $error("read data not zero outside an answer");
  AST_MC_IDLE: assert property (disable iff (!i_arst_n) i_master_clear [*6] |->
    o_serial_tx_out && o_hold_empty_flag && !o_last_bit_flag && !o_no_data_flag)
    else $error("master clear did not give idle outputs");
  AST_OE: assert property ($stable(i_chip_off) [*4] |-> o_serial_tx_oe == !i_chip_off)
    else $error("output enable does not follow chip off");
  AST_LOAD_CLR: assert property ((!i_hold_load_n && !i_chip_off) [*4] |-> !o_no_data_flag)
    else $error("no data flag high while a character is loaded");
  AST_START_EMPTY: assert property ($rose(o_last_bit_flag) && i_hold_load_n && $past(i_hold_load_n) && $past(i_hold_load_n, 2) && $past(i_hold_load_n, 3) |-> o_hold_empty_flag || o_no_data_flag)
    else $error("character started with holding not empty");
  AST_LAST_LOW: assert property ($fell(o_last_bit_flag) |-> !o_last_bit_flag [*6])
    else $error("last bit flag low shorter than a bit");
  AST_CHAR_LEN: assert property ($rose(o_last_bit_flag) |-> o_last_bit_flag [*8])
    else $error("character shorter than the minimum length");
  AST_IDLE_MARK: assert property (!o_last_bit_flag [*8] ##1 !o_last_bit_flag [*4] |->
    o_serial_tx_out)
    else $error("idle line not at mark");
  COV_FILL: cover property ($rose(o_no_data_flag));
  COV_IRQ: cover property ($rose(o_irq));
  COV_IDLE: cover property (!o_last_bit_flag [*8] ##1 !o_last_bit_flag [*4]);
endmodule // sct_transmitter_chk
bind sct_transmitter sct_transmitter_chk u_sct_transmitter_chk (.*);
